// file: fpm_far_end.sv
// Purpose: Far-end logic model that drives or receives one multipurpose pin.
// Assumes: Drive requests change just after a rising edge of i_ref_clk.
// Notes:   A floating pin without pull-down reads as the inverse of last.
`timescale 1ns/1ps
module fpm_far_end #(
  parameter int SLOW = 0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_dut_out,
  input  wire logic i_dut_oe,
  input  wire logic i_dut_pd,
  input  wire logic i_drv_en,
  input  wire logic i_drv_val,
  output logic      o_level
);
  logic en_reg;
  logic val_reg;
  logic last_reg;

  // A slow partner takes effect one clock after it is told to drive.
  always_ff @(posedge i_ref_clk)
  begin
    en_reg   <= i_drv_en;
    val_reg  <= i_drv_val;
    last_reg <= o_level;
  end

  // Device drive wins, then ours, then the weak pull-down, else it floats.
  always_comb
  begin
    if (i_dut_oe)
      o_level = i_dut_out;
    else if ((SLOW != 0) ? en_reg : i_drv_en)
      o_level = (SLOW != 0) ? val_reg : i_drv_val;
    else if (i_dut_pd)
      o_level = 1'b0;
    else
      o_level = ~last_reg;
  end
endmodule // fpm_far_end

// file: fpm_pin_mux.sv
// Purpose: Function selection for the A-side and B-side multipurpose pins.
// Assumes: Pin levels and register strobes are synchronous to i_ref_clk.
// Notes:   Pin drive, enable and pull-down come from flops, one cycle late.
//
// What this block does
// R1 - Pin A primary 000 drives A threshold flag; 001 drives multiframe clock.
// R2 - Pin A primary 110 takes function from secondary bits [3:0].
// R3 - Pin A primary 111, the reset default, leaves pin undriven, pulled down.
// R4 - Pin B primary 111, the reset default, leaves pin undriven, pulled down.
// R5 - Pin B primary uses same codes; 110 defers to secondary bits [7:4].
// R6 - Pin B secondary is ignored unless pin B primary holds 110.
// R7 - Pin A secondary is ignored unless pin A primary holds 110.
// R8 - Pin B secondary 0000 is NCO select input, 0001 chip transfer input.
// R9 - Pin A secondary 0000 is NCO select input, 0001 chip transfer input.
// R10 - Secondary 1000 drives the pin as master next-trigger output.
// R11 - Secondary 1001 makes the pin a slave next-trigger input.
// R12 - Both secondary selectors reset to 0x0, the NCO select function.
// R13 - Chip transfer copies staged phase and filter values into active.
// R14 - Unlisted selector codes leave the pin a pulled-down input.
`timescale 1ns/1ps
module fpm_pin_mux #(
  parameter int PHASE_W = 48,
  parameter int COEF_W  = 64
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_arst_n,
  // Byte-wide configuration register port.
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [15:0]           i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  // Internal sources that may be routed to the pins.
  input  wire logic                  i_threshold_flag_a,
  input  wire logic                  i_threshold_flag_b,
  input  wire logic                  i_lmfc_clk,
  input  wire logic                  i_master_trigger_out,
  // Pin A as input, output and output enable, plus weak pull-down.
  input  wire logic                  i_general_pin_a_zero,
  output logic                       o_general_pin_a_zero,
  output logic                       o_general_pin_a_zero_oe,
  output logic                       o_general_pin_a_zero_pd,
  // Pin B as input, output and output enable, plus weak pull-down.
  input  wire logic                  i_general_pin_b_zero,
  output logic                       o_general_pin_b_zero,
  output logic                       o_general_pin_b_zero_oe,
  output logic                       o_general_pin_b_zero_pd,
  // Functions recovered from the pins.
  output logic                       o_nco_chan_sel_a,
  output logic                       o_nco_chan_sel_b,
  output logic                       o_slave_trigger_in,
  output logic                       o_chip_xfer,
  // Staged and active NCO and programmable filter values.
  input  wire logic [PHASE_W-1:0]    i_staged_phase_inc,
  input  wire logic [PHASE_W-1:0]    i_staged_phase_ofs,
  input  wire logic [COEF_W-1:0]     i_staged_programmable_filter,
  output logic      [PHASE_W-1:0]    o_active_phase_inc,
  output logic      [PHASE_W-1:0]    o_active_phase_ofs,
  output logic      [COEF_W-1:0]     o_active_programmable_filter
);
  import fpm_pkg::*;

  logic [7:0]        pin_control_primary_reg;
  logic [7:0]        pin_control_secondary_reg;
  logic [7:0]        rdata_reg;
  logic [1:0]        pin_in;
  logic [1:0]        pin_in_reg;
  logic [1:0]        internal_src;
  logic [2:0]        pri [2];
  logic [3:0]        sec [2];
  fpm_func_t         func [2];
  logic [1:0]        pin_out_reg;
  logic [1:0]        pin_oe_reg;
  logic [1:0]        pin_pd_reg;
  logic [1:0]        nco_sel_reg;
  logic [1:0]        xfer_edge;
  logic [1:0]        trig_in_hit;
  logic              slave_trig_reg;
  logic              chip_xfer_reg;

  // Pins and flags gathered into per-pin vectors, A at index 0.
  assign pin_in       = {i_general_pin_b_zero, i_general_pin_a_zero};
  assign internal_src = {i_threshold_flag_b, i_threshold_flag_a};

  // Configuration registers; primary bits [7:6] are kept for the power-down logic.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_control_primary_reg   <= FPM_RST_PIN_PRIMARY;   // R3 R4
      pin_control_secondary_reg <= FPM_RST_PIN_SECONDARY; // R12
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == FPM_OFS_PIN_PRIMARY)
        pin_control_primary_reg <= i_reg_wdata;
      if (i_reg_addr == FPM_OFS_PIN_SECONDARY)
        pin_control_secondary_reg <= i_reg_wdata;
    end
  end

  // Read data is registered; unmapped offsets read as zero.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rdata_reg <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        FPM_OFS_PIN_PRIMARY:   rdata_reg <= pin_control_primary_reg;
        FPM_OFS_PIN_SECONDARY: rdata_reg <= pin_control_secondary_reg;
        default:               rdata_reg <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_reg;

  // Field slicing: each pin sees its own primary and secondary selector.
  assign pri[0] = pin_control_primary_reg[FPM_PRI_A_LSB +: FPM_PRI_W];
  assign pri[1] = pin_control_primary_reg[FPM_PRI_B_LSB +: FPM_PRI_W];
  assign sec[0] = pin_control_secondary_reg[FPM_SEC_A_LSB +: FPM_SEC_W];
  assign sec[1] = pin_control_secondary_reg[FPM_SEC_B_LSB +: FPM_SEC_W];

  // Previous pin level, used only to find transfer strobe rising edges.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_in_reg <= 2'h0;
    else
      pin_in_reg <= pin_in;
  end

  // One copy of the pin logic per pin; the decode looks at the secondary
  // field only on primary code 110, so a stale secondary does no harm.
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    assign func[p] = fpm_decode(pri[p], sec[p]); // R2 R5 R6 R7 R14

    // Drive, enable and pull-down all flop together so the pin never
    // sees an enable paired with the previous function's data.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
      begin
        pin_out_reg[p] <= 1'b0;
        pin_oe_reg[p]  <= 1'b0;
        pin_pd_reg[p]  <= 1'b1;
      end
      else
      begin
        case (func[p])
          FPM_FN_DETECT:
          begin
            pin_out_reg[p] <= internal_src[p]; // R1 R5
            pin_oe_reg[p]  <= 1'b1;
            pin_pd_reg[p]  <= 1'b0;
          end
          FPM_FN_LMFC:
          begin
            pin_out_reg[p] <= i_lmfc_clk; // R1 R5
            pin_oe_reg[p]  <= 1'b1;
            pin_pd_reg[p]  <= 1'b0;
          end
          FPM_FN_TRIG_OUT:
          begin
            pin_out_reg[p] <= i_master_trigger_out; // R10
            pin_oe_reg[p]  <= 1'b1;
            pin_pd_reg[p]  <= 1'b0;
          end
          FPM_FN_NCO, FPM_FN_XFER, FPM_FN_TRIG_IN:
          begin
            pin_out_reg[p] <= 1'b0; // R8 R9 R11
            pin_oe_reg[p]  <= 1'b0;
            pin_pd_reg[p]  <= 1'b0;
          end
          default:
          begin
            pin_out_reg[p] <= 1'b0; // R3 R4 R14
            pin_oe_reg[p]  <= 1'b0;
            pin_pd_reg[p]  <= 1'b1;
          end
        endcase
      end
    end

    // NCO channel select follows the pin only while so selected.
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        nco_sel_reg[p] <= 1'b0;
      else if (func[p] == FPM_FN_NCO)
        nco_sel_reg[p] <= pin_in[p]; // R8 R9
      else
        nco_sel_reg[p] <= 1'b0;
    end

    assign xfer_edge[p] = (func[p] == FPM_FN_XFER)
                          && pin_in[p] && !pin_in_reg[p]; // R8 R9
    assign trig_in_hit[p] = (func[p] == FPM_FN_TRIG_IN) && pin_in[p]; // R11
  end

  // Recovered strobes; a slave trigger on either pin is merged.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      slave_trig_reg <= 1'b0;
      chip_xfer_reg  <= 1'b0;
    end
    else
    begin
      slave_trig_reg <= |trig_in_hit; // R11
      chip_xfer_reg  <= |xfer_edge; // R13
    end
  end

  assign o_general_pin_a_zero    = pin_out_reg[0];
  assign o_general_pin_a_zero_oe = pin_oe_reg[0];
  assign o_general_pin_a_zero_pd = pin_pd_reg[0];
  assign o_general_pin_b_zero    = pin_out_reg[1];
  assign o_general_pin_b_zero_oe = pin_oe_reg[1];
  assign o_general_pin_b_zero_pd = pin_pd_reg[1];
  assign o_nco_chan_sel_a        = nco_sel_reg[0];
  assign o_nco_chan_sel_b        = nco_sel_reg[1];
  assign o_slave_trigger_in      = slave_trig_reg;
  assign o_chip_xfer             = chip_xfer_reg;

  // Mixer phase and filter taps switch together on the transfer pulse,
  // which keeps both mixer frequencies coherent.
  fpm_shadow #(.WIDTH(PHASE_W)) u_phase_inc (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_load    (chip_xfer_reg), // R13
    .i_staged  (i_staged_phase_inc),
    .o_active  (o_active_phase_inc)
  );

  fpm_shadow #(.WIDTH(PHASE_W)) u_phase_ofs (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_load    (chip_xfer_reg), // R13
    .i_staged  (i_staged_phase_ofs),
    .o_active  (o_active_phase_ofs)
  );

  fpm_shadow #(.WIDTH(COEF_W)) u_filter (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_load    (chip_xfer_reg), // R13
    .i_staged  (i_staged_programmable_filter),
    .o_active  (o_active_programmable_filter)
  );

  // Checks on pin drive and recovered functions against the selectors one cycle earlier, save a_b_sec_ignored (same cycle) and a_xfer_copy (two cycles).
  property p_a_detect;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[0] == FPM_PRI_DETECT) |=>
      (o_general_pin_a_zero_oe && o_general_pin_a_zero
       == $past(i_threshold_flag_a));
  endproperty
  a_a_detect: assert property (p_a_detect) // R1
    else $error("Pin A does not carry the A threshold flag.");

  property p_a_lmfc;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[0] == FPM_PRI_LMFC) |=>
      (o_general_pin_a_zero_oe && o_general_pin_a_zero == $past(i_lmfc_clk));
  endproperty
  a_a_lmfc: assert property (p_a_lmfc) // R1
    else $error("Pin A does not carry the multiframe clock.");

  property p_a_off;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[0] == FPM_PRI_OFF) |=>
      (!o_general_pin_a_zero_oe && o_general_pin_a_zero_pd);
  endproperty
  a_a_off: assert property (p_a_off) // R3
    else $error("Disabled pin A is driven or not pulled down.");

  property p_b_off;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[1] == FPM_PRI_OFF) |=>
      (!o_general_pin_b_zero_oe && o_general_pin_b_zero_pd);
  endproperty
  a_b_off: assert property (p_b_off) // R4
    else $error("Disabled pin B is driven or not pulled down.");

  property p_b_detect;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[1] == FPM_PRI_DETECT) |=>
      (o_general_pin_b_zero_oe && o_general_pin_b_zero
       == $past(i_threshold_flag_b));
  endproperty
  a_b_detect: assert property (p_b_detect) // R5
    else $error("Pin B does not carry the B threshold flag.");

  property p_b_sec_ignored;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[1] != FPM_PRI_SECOND) |-> (!trig_in_hit[1] && !xfer_edge[1]);
  endproperty
  a_b_sec_ignored: assert property (p_b_sec_ignored) // R6
    else $error("Pin B secondary used without primary code 110.");

  property p_a_sec_ignored;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[0] != FPM_PRI_SECOND) |=> !o_nco_chan_sel_a;
  endproperty
  a_a_sec_ignored: assert property (p_a_sec_ignored) // R7
    else $error("Pin A secondary used without primary code 110.");

  property p_trig_out;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[0] == FPM_PRI_SECOND && sec[0] == FPM_SEC_TRIG_OUT) |=>
      (o_general_pin_a_zero_oe
       && o_general_pin_a_zero == $past(i_master_trigger_out));
  endproperty
  a_trig_out: assert property (p_trig_out) // R10
    else $error("Pin A does not drive the master trigger.");

  property p_trig_in;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (func[1] == FPM_FN_TRIG_IN && i_general_pin_b_zero) |=>
      (o_slave_trigger_in && !o_general_pin_b_zero_oe);
  endproperty
  a_trig_in: assert property (p_trig_in) // R11
    else $error("Slave trigger on pin B not seen or pin driven.");

  property p_xfer_copy;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (func[0] == FPM_FN_XFER && i_general_pin_a_zero
     && !pin_in_reg[0]) ##1 $stable(i_staged_phase_inc) |=>
      (o_active_phase_inc == $past(i_staged_phase_inc));
  endproperty
  a_xfer_copy: assert property (p_xfer_copy) // R13
    else $error("Chip transfer did not load the staged phase step.");

  property p_reserved;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (pri[1] inside {3'h2, 3'h3, 3'h4, 3'h5}) |=>
      (!o_general_pin_b_zero_oe && o_general_pin_b_zero_pd);
  endproperty
  a_reserved: assert property (p_reserved) // R14
    else $error("Reserved primary code on pin B left the pin driven.");

endmodule // fpm_pin_mux

// file: fpm_pin_mux_tb.sv
// Purpose: Self-checking bench for the multipurpose pin function mux.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Pin B partner is slow, so input checks wait three edges.
`timescale 1ns/1ps
module fpm_pin_mux_tb;
  import fpm_pkg::*;
  logic        ref_clk, arst_n, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        flag_a, flag_b, lmfc, mtrig, pin_a, pin_b;
  logic        out_a, oe_a, pd_a, out_b, oe_b, pd_b;
  logic        nco_a, nco_b, strig, xfer;
  logic        en_a, val_a, en_b, val_b;
  logic [47:0] st_inc, st_ofs, ac_inc, ac_ofs;
  logic [63:0] st_flt, ac_flt;
  int          miscompares, num_checks, cycles;

  fpm_pin_mux i_fpm_pin_mux (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_threshold_flag_a(flag_a),
    .i_threshold_flag_b(flag_b), .i_lmfc_clk(lmfc),
    .i_master_trigger_out(mtrig), .i_general_pin_a_zero(pin_a),
    .o_general_pin_a_zero(out_a), .o_general_pin_a_zero_oe(oe_a),
    .o_general_pin_a_zero_pd(pd_a), .i_general_pin_b_zero(pin_b),
    .o_general_pin_b_zero(out_b), .o_general_pin_b_zero_oe(oe_b),
    .o_general_pin_b_zero_pd(pd_b), .o_nco_chan_sel_a(nco_a),
    .o_nco_chan_sel_b(nco_b), .o_slave_trigger_in(strig),
    .o_chip_xfer(xfer), .i_staged_phase_inc(st_inc),
    .i_staged_phase_ofs(st_ofs), .i_staged_programmable_filter(st_flt),
    .o_active_phase_inc(ac_inc), .o_active_phase_ofs(ac_ofs),
    .o_active_programmable_filter(ac_flt));

  fpm_far_end #(.SLOW(0)) i_fpm_far_end_a (
    .i_ref_clk(ref_clk), .i_dut_out(out_a), .i_dut_oe(oe_a),
    .i_dut_pd(pd_a), .i_drv_en(en_a), .i_drv_val(val_a), .o_level(pin_a));
  fpm_far_end #(.SLOW(1)) i_fpm_far_end_b (
    .i_ref_clk(ref_clk), .i_dut_out(out_b), .i_dut_oe(oe_b),
    .i_dut_pd(pd_b), .i_drv_en(en_b), .i_drv_val(val_b), .o_level(pin_b));

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hang is cut short well beyond the fewer than a hundred cycles needed.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("Error timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk_pins(input logic ea, pa, eb, pb);
    chk("oe_a", ea, oe_a);
    chk("pd_a", pa, pd_a);
    chk("oe_b", eb, oe_b);
    chk("pd_b", pb, pd_b);
  endtask

  task automatic t_reset();
    reg_read(16'h0040, d);
    chk("primary", 8'h3f, d);
    reg_read(16'h0041, d);
    chk("secondary", 8'h00, d);
    chk_pins(1'b0, 1'b1, 1'b0, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_direct();
    reg_write(16'h0040, 8'h08);
    flag_a <= 1'b1;
    flag_b <= 1'b1;
    lmfc   <= 1'b0;
    wait_n(2);
    chk_pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk("out_a", 1'b1, out_a);
    chk("out_b", 1'b0, out_b);
    reg_write(16'h0040, 8'h01);
    reg_write(16'h0041, 8'h99);
    flag_a <= 1'b0;
    flag_b <= 1'b0;
    lmfc   <= 1'b1;
    wait_n(2);
    chk_pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk("out_a", 1'b1, out_a);
    chk("out_b", 1'b0, out_b);
    chk("strig", 1'b0, strig);
    $display("test direct done");
  endtask

  task automatic t_second();
    logic [3:0] c;
    logic [3:0] codes [4];
    codes = '{FPM_SEC_NCO, FPM_SEC_XFER, FPM_SEC_TRIG_OUT, FPM_SEC_TRIG_IN};
    reg_write(16'h0040, 8'h36);
    foreach (codes[i])
    begin
      c = codes[i];
      reg_write(16'h0041, {c, c});
      mtrig <= 1'b1;
      en_a  <= (c != 4'h8);
      val_a <= (c != 4'h9);
      en_b  <= (c != 4'h8);
      val_b <= 1'b1;
      wait_n(3);
      chk_pins(c == 4'h8, 1'b0, c == 4'h8, 1'b0);
      chk("out_a", c == 4'h8, out_a);
      chk("out_b", c == 4'h8, out_b);
      chk("nco_a", c == 4'h0, nco_a);
      chk("nco_b", c == 4'h0, nco_b);
      chk("strig", c == 4'h9, strig);
    end
    $display("test secondary done");
  endtask

  task automatic t_reserved();
    reg_write(16'h0040, 8'h1a);
    reg_write(16'h0041, 8'h00);
    wait_n(2);
    chk_pins(1'b0, 1'b1, 1'b0, 1'b1);
    reg_write(16'h0040, 8'h36);
    reg_write(16'h0041, 8'h25);
    wait_n(2);
    chk_pins(1'b0, 1'b1, 1'b0, 1'b1);
    reg_write(16'h0040, 8'h3f);
    reg_write(16'h0041, 8'h88);
    wait_n(2);
    chk_pins(1'b0, 1'b1, 1'b0, 1'b1);
    reg_write(16'h0042, 8'hff);
    reg_read(16'h0042, d);
    chk("unmapped", 8'h00, d);
    reg_read(16'h0041, d);
    chk("secondary", 8'h88, d);
    $display("test reserved done");
  endtask

  // Pin B strobes through the slow partner, so the wait is bounded loosely.
  task automatic t_xfer(input logic use_b);
    reg_write(16'h0040, 8'h36);
    reg_write(16'h0041, use_b ? 8'h10 : 8'h01);
    en_a  <= 1'b1;
    en_b  <= 1'b1;
    val_a <= 1'b0;
    val_b <= 1'b0;
    wait_n(3);
    chk("xfer", 1'b0, xfer);
    chk("nco_low", 1'b0, use_b ? nco_a : nco_b);
    @(posedge ref_clk);
    if (use_b)
      val_b <= 1'b1;
    else
      val_a <= 1'b1;
    for (int k = 0; k < 5 && xfer !== 1'b1; k++)
      wait_n(1);
    chk("xfer", 1'b1, xfer);
    wait_n(1);
    chk("xfer", 1'b0, xfer);
    chk("inc", st_inc, ac_inc);
    chk("ofs", st_ofs, ac_ofs);
    chk("flt", st_flt, ac_flt);
    $display("test transfer done");
  endtask

  // Reset for four cycles, then run every scenario in turn.
  initial
  begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, flag_a, flag_b, lmfc, mtrig} = '0;
    {en_a, val_a, en_b, val_b} = '0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    st_inc = 48'h123456789abc;
    st_ofs = 48'h0fedcba98765;
    st_flt = 64'h0123456789abcdef;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    chk("inc", 48'h0, ac_inc);
    t_reset();
    t_direct();
    t_second();
    t_reserved();
    t_xfer(1'b0);
    @(posedge ref_clk);
    st_inc <= 48'h5a5a5a5a5a5a;
    st_flt <= 64'hfedcba9876543210;
    t_xfer(1'b1);
    finish_test();
  end
endmodule // fpm_pin_mux_tb

// file: fpm_pkg.sv
// Purpose: Shared constants and types for the fast-detect pin function mux.
// Assumes: One 40 MHz register clock, byte-wide configuration registers.
// Notes:   Offsets, field positions, resets and codes are named only here.
package fpm_pkg;

  // Register offsets on the byte-wide configuration port.
  localparam logic [15:0] FPM_OFS_PIN_PRIMARY   = 16'h0040;
  localparam logic [15:0] FPM_OFS_PIN_SECONDARY = 16'h0041;

  // Field positions: pin A primary [2:0], pin B primary [5:3].
  localparam int FPM_PRI_A_LSB = 0;
  localparam int FPM_PRI_B_LSB = 3;
  localparam int FPM_PRI_W     = 3;
  // Field positions: pin A secondary [3:0], pin B secondary [7:4].
  localparam int FPM_SEC_A_LSB = 0;
  localparam int FPM_SEC_B_LSB = 4;
  localparam int FPM_SEC_W     = 4;

  // Reset values; power-down bits [7:6] of the primary register reset to 0.
  localparam logic [7:0] FPM_RST_PIN_PRIMARY   = 8'h3f;
  localparam logic [7:0] FPM_RST_PIN_SECONDARY = 8'h00;

  // Primary selector codes.
  localparam logic [2:0] FPM_PRI_DETECT = 3'h0;
  localparam logic [2:0] FPM_PRI_LMFC   = 3'h1;
  localparam logic [2:0] FPM_PRI_SECOND = 3'h6;
  localparam logic [2:0] FPM_PRI_OFF    = 3'h7;

  // Secondary selector codes.
  localparam logic [3:0] FPM_SEC_NCO      = 4'h0;
  localparam logic [3:0] FPM_SEC_XFER     = 4'h1;
  localparam logic [3:0] FPM_SEC_TRIG_OUT = 4'h8;
  localparam logic [3:0] FPM_SEC_TRIG_IN  = 4'h9;

  // Resolved function of one pin.
  typedef enum logic [2:0] {
    FPM_FN_OFF      = 3'b000,
    FPM_FN_DETECT   = 3'b001,
    FPM_FN_LMFC     = 3'b010,
    FPM_FN_NCO      = 3'b011,
    FPM_FN_XFER     = 3'b100,
    FPM_FN_TRIG_OUT = 3'b101,
    FPM_FN_TRIG_IN  = 3'b110
  } fpm_func_t;

  // Resolve a pin from its two selectors; unknown codes leave it off.
  function automatic fpm_func_t fpm_decode(input logic [2:0] pri,
                                           input logic [3:0] sec);
    fpm_func_t fn;
    fn = FPM_FN_OFF;
    case (pri)
      FPM_PRI_DETECT: fn = FPM_FN_DETECT;
      FPM_PRI_LMFC:   fn = FPM_FN_LMFC;
      FPM_PRI_SECOND:
      begin
        case (sec)
          FPM_SEC_NCO:      fn = FPM_FN_NCO;
          FPM_SEC_XFER:     fn = FPM_FN_XFER;
          FPM_SEC_TRIG_OUT: fn = FPM_FN_TRIG_OUT;
          FPM_SEC_TRIG_IN:  fn = FPM_FN_TRIG_IN;
          default:          fn = FPM_FN_OFF;
        endcase
      end
      default:        fn = FPM_FN_OFF;
    endcase
    return fn;
  endfunction

endpackage

// file: fpm_shadow.sv
// Purpose: Staged-to-active copy register loaded by a transfer strobe.
// Assumes: Strobe is a one-cycle pulse in the register clock domain.
// Notes:   Active value holds zero after reset until the first transfer.
`timescale 1ns/1ps
module fpm_shadow #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_staged,
  output logic      [WIDTH-1:0] o_active
);
  import fpm_pkg::*;

  logic [WIDTH-1:0] active_reg;

  // Copy only on the strobe so every consumer switches in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      active_reg <= '0;
    else if (i_load)
      active_reg <= i_staged;
  end

  assign o_active = active_reg;

endmodule // fpm_shadow
